// >>> core/rbs_pkg.sv
// package of constants for the reset and brown-out sequencer
`default_nettype none
package rbs_pkg;
	// wishbone register word offsets (byte addresses)
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_CAUSE  = 8'h04;
	localparam logic [7:0] REG_MASK   = 8'h08;
	localparam logic [7:0] REG_OSC    = 8'h0C;
	localparam logic [7:0] REG_STATE  = 8'h10;
	// control register fields
	localparam int CTRL_MON_EN   = 0;
	localparam int CTRL_PUT_EN   = 1;
	localparam int CTRL_BOR_EN   = 2;
	localparam int CTRL_TRIP_LO  = 3;
	localparam int CTRL_SRC_LO   = 5;
	localparam int CTRL_MODE_LO  = 8;
	localparam int CTRL_PLL_EN   = 13;
	localparam int CTRL_SW_LO    = 14;
	localparam int CTRL_SW_SET   = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0007;
	// reset cause / interrupt status fields
	localparam int CAUSE_POR  = 0;
	localparam int CAUSE_BOR  = 1;
	localparam int CAUSE_TRAP = 2;
	localparam int CAUSE_W    = 3;
	localparam logic [2:0] CAUSE_RESET = 3'h1;
	// oscillator status fields
	localparam int OSC_LOCK = 5;
	// trip point codes
	localparam logic [1:0] TRIP_LOW  = 2'h0;
	localparam logic [1:0] TRIP_MID  = 2'h1;
	localparam logic [1:0] TRIP_HIGH = 2'h2;
	// clock select codes
	localparam logic [1:0] CLK_PRIMARY = 2'h0;
	localparam logic [1:0] CLK_FAST_RC = 2'h1;
	// timing in microseconds and cycles at 10 MHz
	localparam int CLK_MHZ        = 10;
	localparam int POR_DELAY_US   = 2;
	localparam int PUT_DELAY_US   = 64;
	localparam int MON_DELAY_US   = 100;
	localparam int POR_CYC        = POR_DELAY_US * CLK_MHZ;
	localparam int PUT_CYC        = PUT_DELAY_US * CLK_MHZ;
	localparam int MON_CYC        = MON_DELAY_US * CLK_MHZ;
	localparam int BOR_PULSE_US   = 1;
	localparam int BOR_PULSE_CYC  = BOR_PULSE_US * CLK_MHZ;
endpackage : rbs_pkg
`default_nettype wire

// >>> core/rbs_delay.sv
// down counter that reports when a loaded delay has elapsed
`default_nettype none
module rbs_delay #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         sys_rst,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	// status
	output logic              done
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic         done_q;
	logic         done_d;

	// next count
	always_comb begin
		cnt_d  = cnt_q;
		done_d = done_q;
		if (load) begin
			cnt_d  = count;
			done_d = (count == '0);
		end else if (cnt_q != '0) begin
			cnt_d  = cnt_q - 1'b1;
			done_d = (cnt_q == W'(1));
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q  <= '0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			done_q <= done_d;
		end
	end

	assign done = done_q;
endmodule : rbs_delay
`default_nettype wire

// >>> core/rbs_sequencer.sv
// reset release sequencer with brown-out detection and clock fail trap
`default_nettype none
module rbs_sequencer (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// supply monitor pins, one comparator per trip point
	input  wire logic [2:0]  supply_below,
	// oscillator and pll pins
	input  wire logic        osc_running,
	input  wire logic        osc_timer_done,
	input  wire logic        pll_lock,
	input  wire logic        sys_clk_running,
	input  wire logic        low_power_mode,
	// outputs to the device
	output logic             dev_rst,
	output logic             bor_pulse,
	output logic             osc_timer_start,
	output logic             clk_gate_en,
	output logic [1:0]       clk_sel,
	output logic             core_run,
	output logic             irq
);
	typedef enum {ST_POR, ST_WAIT, ST_RUN, ST_BOR} rbs_state_e;

	// synchronised pins
	logic [7:0] s1_q;
	logic [7:0] s2_q;
	logic [2:0] below;
	logic       osc_ok;
	logic       ost_ok;
	logic       lock_ok;
	logic       clk_ok;
	assign below   = s2_q[2:0];
	assign osc_ok  = s2_q[3];
	assign ost_ok  = s2_q[4];
	assign lock_ok = s2_q[5];
	assign clk_ok  = s2_q[6];

	// registers
	logic [31:0]           ctrl_q, ctrl_d;
	logic [2:0]            cause_q, cause_d;
	logic [2:0]            mask_q, mask_d;
	logic [31:0]           dat_q, dat_d;
	logic                  ack_q, ack_d;
	logic                  err_q, err_d;
	rbs_state_e            st_q, st_d;
	logic [15:0]           pulse_q, pulse_d;
	logic                  rst_q, rst_d;
	logic                  gate_q, gate_d;
	logic [1:0]            sel_q, sel_d;
	logic                  ost_q, ost_d;
	logic                  run_q, run_d;
	logic                  irq_q, irq_d;
	logic                  bor_q, bor_d;
	logic [2:0]            cause_clr;
	logic                  dly_load;
	logic [15:0]           dly_cnt;
	logic                  dly_done;

	// decode of configuration fields
	logic                  mon_en, put_en, bor_en, pll_en, crystal;
	logic [1:0]            trip;
	logic [2:0]            src_sel;
	logic [4:0]            mode_sel;
	assign mon_en   = ctrl_q[rbs_pkg::CTRL_MON_EN];
	assign put_en   = ctrl_q[rbs_pkg::CTRL_PUT_EN];
	assign bor_en   = ctrl_q[rbs_pkg::CTRL_BOR_EN];
	assign trip     = ctrl_q[rbs_pkg::CTRL_TRIP_LO +: 2];
	assign src_sel  = ctrl_q[rbs_pkg::CTRL_SRC_LO +: 3];
	assign mode_sel = ctrl_q[rbs_pkg::CTRL_MODE_LO +: 5];
	assign pll_en   = ctrl_q[rbs_pkg::CTRL_PLL_EN];
	// primary source with a nonzero mode means a crystal oscillator
	assign crystal  = (src_sel == 3'h7) && (mode_sel != 5'h00);

	// brown-out comparator chosen by trip point; active in sleep/idle too
	function automatic logic trip_hit(input logic [1:0] t, input logic [2:0] b);
		case (t)
			rbs_pkg::TRIP_LOW:  trip_hit = b[0];
			rbs_pkg::TRIP_MID:  trip_hit = b[1];
			rbs_pkg::TRIP_HIGH: trip_hit = b[2];
			default:            trip_hit = b[2];
		endcase
	endfunction : trip_hit

	logic brown;
	assign brown = bor_en && trip_hit(trip, below);

	// clock qualified for release: oscillator, start-up timer, pll
	logic clk_ready;
	assign clk_ready = (!crystal || (osc_ok && ost_ok)) && (!pll_en || lock_ok);

	// bus access
	logic wr, rd, hit;
	assign wr  = wb_cyc_i && wb_stb_i && !ack_q && !err_q && wb_we_i;
	assign rd  = wb_cyc_i && wb_stb_i && !ack_q && !err_q && !wb_we_i;
	assign hit = (wb_adr_i == rbs_pkg::REG_CTRL) || (wb_adr_i == rbs_pkg::REG_CAUSE) ||
		(wb_adr_i == rbs_pkg::REG_MASK) || (wb_adr_i == rbs_pkg::REG_OSC) ||
		(wb_adr_i == rbs_pkg::REG_STATE);

	// delay length chosen by configuration
	always_comb begin
		dly_cnt = 16'(rbs_pkg::POR_CYC);
		if (put_en) begin
			dly_cnt = 16'(rbs_pkg::PUT_CYC);
		end else if (crystal) begin
			dly_cnt = 16'(rbs_pkg::POR_CYC + rbs_pkg::MON_CYC);
		end else if (!mon_en) begin
			dly_cnt = 16'h0001;
		end
	end

	// delay counter
	rbs_delay #(.W(16)) u_delay (
		.clk     (clk),
		.sys_rst (sys_rst),
		.load    (dly_load),
		.count   (dly_cnt),
		.done    (dly_done)
	);

	// sequencer next state
	always_comb begin
		st_d     = st_q;
		pulse_d  = pulse_q;
		rst_d    = rst_q;
		gate_d   = gate_q;
		sel_d    = sel_q;
		ost_d    = 1'b0;
		run_d    = run_q;
		dly_load = 1'b0;
		cause_d  = cause_q & ~cause_clr; // clear first, sets below win
		if (brown && st_q != ST_BOR) begin
			st_d     = ST_BOR;
			pulse_d  = 16'(rbs_pkg::BOR_PULSE_CYC);
			rst_d    = 1'b1;
			gate_d   = 1'b0;
			run_d    = 1'b0;
			cause_d[rbs_pkg::CAUSE_BOR] = 1'b1;
		end else begin
			case (st_q)
				ST_POR: begin
					dly_load = 1'b1;
					ost_d    = crystal; // timer runs independently
					st_d     = ST_WAIT;
				end
				ST_WAIT: begin
					// release only after delays; clock checked separately
					if (dly_done && !dly_load) begin
						rst_d = 1'b0;
						if (clk_ready) begin
							gate_d = 1'b1;
							sel_d  = rbs_pkg::CLK_PRIMARY;
						end else if (mon_en) begin
							gate_d = 1'b1;
							sel_d  = rbs_pkg::CLK_FAST_RC;
							cause_d[rbs_pkg::CAUSE_TRAP] = 1'b1;
						end
						st_d = ST_RUN;
					end
				end
				ST_RUN: begin
					// late clock arrival without monitor
					if (!gate_q && clk_ready) begin
						gate_d = 1'b1;
					end
					run_d = gate_q && (clk_ok || sel_q == rbs_pkg::CLK_FAST_RC);
					if (ctrl_q[rbs_pkg::CTRL_SW_SET] && clk_ready) begin
						sel_d = ctrl_q[rbs_pkg::CTRL_SW_LO +: 2]; // software clock reselect
					end
				end
				ST_BOR: begin
					if (pulse_q != '0) begin
						pulse_d = pulse_q - 1'b1;
					end else if (!brown) begin
						st_d = ST_POR; // restart oscillator and delays
					end
				end
				default: st_d = ST_POR;
			endcase
		end
		bor_d = (st_d == ST_BOR); // pulse flag kept in its own flop
	end

	// register file next values; hardware set wins over write-one-clear
	always_comb begin
		ctrl_d    = ctrl_q;
		mask_d    = mask_q;
		cause_clr = 3'h0;
		dat_d  = 32'h0000_0000;
		ack_d  = 1'b0;
		err_d  = 1'b0;
		if (wr && hit) begin
			ack_d = 1'b1;
			case (wb_adr_i)
				rbs_pkg::REG_CTRL: begin
					for (int i = 0; i < 4; i++) begin
						if (wb_sel_i[i]) begin
							ctrl_d[i*8 +: 8] = wb_dat_i[i*8 +: 8];
						end
					end
				end
				rbs_pkg::REG_CAUSE: begin
					if (wb_sel_i[0]) begin
						cause_clr = wb_dat_i[2:0];
					end
				end
				rbs_pkg::REG_MASK: begin
					if (wb_sel_i[0]) begin
						mask_d = wb_dat_i[2:0];
					end
				end
				default: ;
			endcase
		end else if (rd && hit) begin
			ack_d = 1'b1;
			case (wb_adr_i)
				rbs_pkg::REG_CTRL:  dat_d = ctrl_q;
				rbs_pkg::REG_CAUSE: dat_d = {29'h0, cause_q};
				rbs_pkg::REG_MASK:  dat_d = {29'h0, mask_q};
				rbs_pkg::REG_OSC:   dat_d = {26'h0, lock_ok, 2'h0, osc_ok, sel_q};
				rbs_pkg::REG_STATE: dat_d = {27'h0, run_q, gate_q, rst_q, 2'(st_q)};
				default:            dat_d = 32'h0000_0000;
			endcase
		end else if (wb_cyc_i && wb_stb_i && !ack_q && !err_q) begin
			err_d = 1'b1; // unmapped address
		end
	end

	// level interrupt from next status and mask
	assign irq_d = |(cause_d & mask_d);

	// all registers; cause and control survive the brown-out pulse
	always_ff @(posedge clk) begin
		s1_q <= {low_power_mode, sys_clk_running, pll_lock, osc_timer_done,
			osc_running, supply_below};
		s2_q <= s1_q;
		if (sys_rst) begin
			ctrl_q  <= rbs_pkg::CTRL_RESET;
			cause_q <= rbs_pkg::CAUSE_RESET;
			mask_q  <= 3'h0;
			dat_q   <= 32'h0000_0000;
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			st_q    <= ST_POR;
			pulse_q <= 16'h0000;
			rst_q   <= 1'b1;
			gate_q  <= 1'b0;
			sel_q   <= rbs_pkg::CLK_PRIMARY;
			ost_q   <= 1'b0;
			run_q   <= 1'b0;
			irq_q   <= 1'b0;
			bor_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			cause_q <= cause_d;
			mask_q  <= mask_d;
			dat_q   <= dat_d;
			ack_q   <= ack_d;
			err_q   <= err_d;
			st_q    <= st_d;
			pulse_q <= pulse_d;
			rst_q   <= rst_d;
			gate_q  <= gate_d;
			sel_q   <= sel_d;
			ost_q   <= ost_d;
			run_q   <= run_d;
			irq_q   <= irq_d;
			bor_q   <= bor_d;
		end
	end

	// outputs straight from flip-flops
	assign wb_dat_o        = dat_q;
	assign wb_ack_o        = ack_q;
	assign wb_err_o        = err_q;
	assign dev_rst         = rst_q;
	assign bor_pulse       = bor_q;
	assign osc_timer_start = ost_q;
	assign clk_gate_en     = gate_q;
	assign clk_sel         = sel_q;
	assign core_run        = run_q;
	assign irq             = irq_q;
endmodule : rbs_sequencer
`default_nettype wire

// >>> verif/rbs_checker.sv
// port checker for the reset and brown-out sequencer
`default_nettype none
module rbs_checker (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// sequencer outputs
	input wire logic dev_rst,
	input wire logic bor_pulse,
	input wire logic osc_timer_start,
	input wire logic clk_gate_en,
	input wire logic core_run
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// pulse body and a fresh bus request
	sequence s_pulse_body;
		bor_pulse [*8];
	endsequence
	sequence s_bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	a_bor_resets: assert property (bor_pulse |=> dev_rst)
		else $error("pulse without reset");
	a_pulse_width: assert property ($rose(bor_pulse) |=> s_pulse_body)
		else $error("pulse too short");
	a_release_late: assert property ($fell(dev_rst) |-> $past(dev_rst, 8))
		else $error("reset released early");
	a_run_clocked: assert property (core_run |-> clk_gate_en && !dev_rst)
		else $error("core runs without clock");
	a_start_pulse: assert property (osc_timer_start |=> !osc_timer_start)
		else $error("timer start too long");
	a_start_in_rst: assert property (osc_timer_start |-> dev_rst)
		else $error("timer start outside reset");
	a_bus_answer: assert property (s_bus_req |=> wb_ack_o || wb_err_o)
		else $error("no bus answer");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_answer_excl: assert property (!(wb_ack_o && wb_err_o))
		else $error("ack with err");
endmodule : rbs_checker
bind rbs_sequencer rbs_checker i_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.wb_err_o, .dev_rst, .bor_pulse, .osc_timer_start, .clk_gate_en, .core_run);
`default_nettype wire

// >>> verif/rbs_osc_model.sv
// oscillator, pll and supply comparator model
`default_nettype none
module rbs_osc_model (
	// clock and bench knobs
	input wire logic        clk,
	input wire logic        osc_stall,
	input wire logic        lock_stall,
	input wire logic [12:0] vdd_mv,
	input wire logic        timer_start,
	// to the sequencer
	output logic            osc_running,
	output logic            osc_timer_done,
	output logic            pll_lock,
	output logic            sys_clk_running,
	output logic [2:0]      supply_below
);
	int cnt = 0;
	// start-up count, free of the power-on timer
	always @(posedge clk) begin
		if (osc_stall || timer_start)
			cnt <= 0;
		else if (cnt < 40)
			cnt <= cnt + 1;
	end
	// levels seen by the sequencer
	assign osc_running     = cnt > 4;
	assign sys_clk_running = cnt > 4;
	assign osc_timer_done  = cnt >= 40;
	assign pll_lock        = osc_timer_done && !lock_stall;
	// one comparator per trip point
	assign supply_below    = {vdd_mv < 13'h11E4, vdd_mv < 13'h1004, vdd_mv < 13'hA28};
endmodule : rbs_osc_model
`default_nettype wire

// >>> verif/rbs_sequencer_test.sv
// self-checking bench for the reset and brown-out sequencer
`default_nettype none
module rbs_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic low_power_mode = 1'b0, osc_stall = 1'b0, lock_stall = 1'b0, ots_seen = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic [12:0] vdd = 13'h1388;
	logic wb_ack_o, wb_err_o, osc_running, osc_timer_done, pll_lock, sys_clk_running;
	logic dev_rst, bor_pulse, osc_timer_start, clk_gate_en, core_run, irq;
	logic [2:0] supply_below;
	logic [1:0] clk_sel;
	int err_total = 0, compares = 0, cycles = 0;
	always #50 clk = ~clk;
	rbs_sequencer i_dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .supply_below, .osc_running, .osc_timer_done,
		.pll_lock, .sys_clk_running, .low_power_mode, .dev_rst, .bor_pulse, .osc_timer_start,
		.clk_gate_en, .clk_sel, .core_run, .irq);
	rbs_osc_model i_osc (.clk, .osc_stall, .lock_stall, .vdd_mv(vdd), .timer_start(osc_timer_start),
		.osc_running, .osc_timer_done, .pll_lock, .sys_clk_running, .supply_below);
	// timer start latch and cycle ceiling
	always @(posedge clk) begin
		if (osc_timer_start)
			ots_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic results();
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one classic bus cycle, held until ack or err
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge clk);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		wb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		wb(1'b0, a, 32'h0, q, e);
		check($sformatf("reg %h", a), q, exp);
	endtask : rd
	// sag the supply until the pulse starts, then restore it and wait for the pulse to end
	task automatic brown(input logic [12:0] v);
		vdd <= v;
		while (bor_pulse !== 1'b1)
			@(posedge clk);
		@(posedge clk);
		check("reset in pulse", dev_rst, 1'b1);
		vdd <= 13'h1388;
		while (bor_pulse !== 1'b0)
			@(posedge clk);
	endtask : brown
	task automatic wait_sig(ref logic s, input logic v, output int n);
		n = 0;
		while (s !== v && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_sig
	task automatic t_boot();
		int n;
		logic [31:0] q;
		logic e;
		rd(8'h00, rbs_pkg::CTRL_RESET);
		rd(8'h04, 32'h1);
		wb(1'b0, 8'h14, 32'h0, q, e);
		check("unmapped err", e, 1'b1);
		wait_sig(dev_rst, 1'b0, n);
		check("boot delay", n + 16 >= rbs_pkg::PUT_CYC, 1'b1);
		wr(8'h04, 32'h7);
	endtask : t_boot
	task automatic t_trap();
		int n;
		logic [31:0] q;
		logic e;
		osc_stall <= 1'b1;
		wr(8'h00, 32'h1E5);
		ots_seen = 1'b0;
		brown(13'h9C4);
		wait_sig(dev_rst, 1'b0, n);
		check("crystal delay", n >= rbs_pkg::POR_CYC + rbs_pkg::MON_CYC && n < 1040,
			1'b1);
		repeat (2) @(posedge clk);
		check("trap clock", clk_sel, rbs_pkg::CLK_FAST_RC);
		check("timer start", ots_seen, 1'b1);
		rd(8'h04, 32'h6);
		osc_stall <= 1'b0;
		wr(8'h04, 32'h6);
		// software moves back to the crystal once it runs
		repeat (60) @(posedge clk);
		wr(8'h00, 32'h0001_01E5);
		repeat (2) @(posedge clk);
		check("sw clock", clk_sel, rbs_pkg::CLK_PRIMARY);
		wb(1'b0, 8'h10, 32'h0, q, e);
		check("run state", q[4:2], 3'h6);
	endtask : t_trap
	task automatic t_hold(input logic [31:0] ctrl);
		int n;
		logic [31:0] q;
		logic e;
		osc_stall <= !ctrl[13];
		lock_stall <= ctrl[13];
		wr(8'h00, ctrl);
		brown(13'h9C4);
		wait_sig(dev_rst, 1'b0, n);
		check("fast exit", n <= rbs_pkg::POR_CYC + 9, 1'b1);
		repeat (30) @(posedge clk);
		// rc source gated at once; pll source waits for lock
		check("held gate", clk_gate_en, !ctrl[13]);
		check("held run", core_run, 1'b0);
		wb(1'b0, 8'h0C, 32'h0, q, e);
		check("lock bit", q[rbs_pkg::OSC_LOCK], 1'b0);
		check("osc bit", q[2], ctrl[13]);
		osc_stall <= 1'b0;
		lock_stall <= 1'b0;
		wait_sig(core_run, 1'b1, n);
		check("clock on", core_run, 1'b1);
	endtask : t_hold
	task automatic t_trips();
		logic [12:0] hi[3] = '{13'hA8C, 13'h1068, 13'h122A};
		logic [12:0] lo[3] = '{13'h9C4, 13'hFA0, 13'h1194};
		int n;
		low_power_mode <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			wr(8'h08, 32'h2);
			wr(8'h00, 32'h24 | 32'(k << 3));
			vdd <= hi[k];
			repeat (10) @(posedge clk);
			check("above trip", dev_rst, 1'b0);
			brown(lo[k]);
			wait_sig(dev_rst, 1'b0, n);
			check("irq raised", irq, 1'b1);
			rd(8'h04, 32'h2);
			wr(8'h08, 32'h0);
			repeat (2) @(posedge clk);
			check("irq masked", irq, 1'b0);
			wr(8'h04, 32'h2);
			rd(8'h04, 32'h0);
		end
	endtask : t_trips
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		t_boot();
		t_trap();
		t_hold(32'h24);
		t_hold(32'h2024);
		t_trips();
		results();
	end
endmodule : rbs_sequencer_test
`default_nettype wire
